//--- shared/clp_regs.svh
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH

// System clock rate and host strobe phase length
`define CLP_SYS_MHZ        10
`define CLP_STROBE_NS      500
`define CLP_DOT_HALF       2

// Palette geometry
`define CLP_ENTRIES        16
`define CLP_ENTRY_W        13
`define CLP_PTR_W          5
`define CLP_PTR_RST        5'h00

// Entry bit layout: A, B, C fields and marking bit
`define CLP_FLD_A_LSB      0
`define CLP_FLD_B_LSB      4
`define CLP_FLD_C_LSB      8
`define CLP_FLD_MARK       12
// Odd byte: marking bit position
`define CLP_ODD_MARK       4

// Pin sampling vector positions
`define CLP_SY_ASTB        0
`define CLP_SY_DSTB        1
`define CLP_SY_RW          2
`define CLP_SY_CSN         3
`define CLP_SY_CSH         4
`define CLP_SY_DOT         5
`define CLP_SY_BLANK       6
`define CLP_SY_MODE        7
`define CLP_SY_PIX         8
`define CLP_SY_AD          12
`define CLP_SY_W           20

// Controller APB register offsets
`define CLP_REG_CTRL       8'h00
`define CLP_REG_CMD        8'h04
`define CLP_REG_STATUS     8'h08
`define CLP_REG_VIDEO      8'h0C

// Control register fields and reset value
`define CLP_CTRL_NONMUX    0
`define CLP_CTRL_ALE       1
`define CLP_CTRL_DOTRUN    2
`define CLP_CTRL_RST       3'h0

// Command register fields
`define CLP_CMD_DATA_LSB   0
`define CLP_CMD_ADDR_LSB   8
`define CLP_CMD_READ       16
`define CLP_CMD_PTR        17

// Status register fields
`define CLP_STAT_BUSY      0
`define CLP_STAT_RDATA_LSB 8

// Video register fields
`define CLP_VID_PIX_LSB    0
`define CLP_VID_BLANK      4

`endif

//--- shared/clp_pkg.sv
package clp_pkg;
`include "clp_regs.svh"

	// Controller bus cycle phases
	typedef enum logic [2:0]
	{
		CLP_IDLE    = 3'b000,
		CLP_ADDR    = 3'b001,
		CLP_LATCH   = 3'b010,
		CLP_DATA    = 3'b011,
		CLP_RECOVER = 3'b100
	} clp_hstate_t;

	// Whole state of the palette end
	typedef struct packed
	{
		logic [`CLP_SY_W-1:0]                        sy1;
		logic [`CLP_SY_W-1:0]                        sy2;
		logic [`CLP_SY_W-1:0]                        sy3;
		logic [`CLP_ENTRIES-1:0][`CLP_ENTRY_W-1:0]   pal;
		logic [`CLP_PTR_W-1:0]                       ptr;
		logic                                        ale_style;
		logic                                        cs_lat;
		logic [3:0]                                  idx;
		logic                                        blank_lat;
		logic [`CLP_ENTRY_W-1:0]                     stage;
		logic                                        stage_blank;
		logic                                        hold;
		logic [11:0]                                 col;
		logic                                        mark;
		logic [7:0]                                  dout;
		logic                                        doe;
	} clp_dev_state_t;

	// Whole state of the controller end
	typedef struct packed
	{
		clp_hstate_t                st;
		logic [7:0]                 cnt;
		logic [2:0]                 ctrl;
		logic [7:0]                 cdata;
		logic [`CLP_PTR_W-1:0]      caddr;
		logic                       cread;
		logic                       cptr;
		logic [7:0]                 rdata;
		logic [3:0]                 pix;
		logic                       blank;
		logic [7:0]                 dot_cnt;
		logic                       dot;
		logic                       astb;
		logic                       dstb;
		logic                       rw;
		logic                       csn;
		logic                       csh;
		logic [7:0]                 bout;
		logic                       boe;
	} clp_host_state_t;
endpackage

//--- shared/clp_link_if.sv
`timescale 1ns/100ps
interface clp_link_if;
	logic       mode_sel;          // High: indirect mode, low: multiplexed
	logic       addr_latch_strobe; // Address latch strobe
	logic       data_strobe;       // Data strobe / read strobe
	logic       rw_sel;            // High read, low write / write strobe
	logic       chip_select_n;     // Active-low select
	logic       chip_select_hi;    // Active-high select
	logic [7:0] host_bus_out;      // Bus value driven by controller
	logic       host_bus_oe;       // Controller drives bus
	logic [7:0] dev_bus_out;       // Bus value driven by palette
	logic       dev_bus_oe;        // Palette drives bus
	logic [7:0] bus;               // Resolved bus level
	logic       dot_clock;         // Pixel rate clock
	logic [3:0] pixel_index;       // Pixel colour index
	logic       blanking;          // Active-high blanking

	// Undriven bus floats to pull-up level
	assign bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 8'hFF);

	modport dev
	(
		input  mode_sel, addr_latch_strobe, data_strobe, rw_sel, chip_select_n, chip_select_hi,
		input  bus, dot_clock, pixel_index, blanking,
		output dev_bus_out, dev_bus_oe
	);

	modport host
	(
		output mode_sel, addr_latch_strobe, data_strobe, rw_sel, chip_select_n, chip_select_hi,
		output host_bus_out, host_bus_oe, dot_clock, pixel_index, blanking,
		input  bus
	);
endinterface

//--- rtl/clp_palette_dev.sv
`timescale 1ns/100ps
module clp_palette_dev
	import clp_pkg::*;
(
	input  wire logic       sys_clk,           // System clock
	input  wire logic       rst,               // Asynchronous reset, active high
	clp_link_if.dev         link,              // Processor and video pins
	output logic      [3:0] colour_out_first,  // First colour code
	output logic      [3:0] colour_out_second, // Second colour code
	output logic      [3:0] colour_out_third,  // Third colour code
	output logic            overlay_flag       // Marking bit output
);

	clp_dev_state_t q;
	clp_dev_state_t n;

	// Read one byte of an entry; spare bits of the odd byte read zero
	function automatic logic [7:0] clp_byte(input logic [`CLP_ENTRY_W-1:0] e, input logic odd);
		logic [7:0] b;
		b = 8'h00;
		if (odd)
		begin
			b[3:0]           = e[`CLP_FLD_C_LSB +: 4];
			b[`CLP_ODD_MARK] = e[`CLP_FLD_MARK];
		end
		else
		begin
			b[3:0] = e[`CLP_FLD_A_LSB +: 4];
			b[7:4] = e[`CLP_FLD_B_LSB +: 4];
		end
		return b;
	endfunction

	// Merge a written byte into an entry; odd bits 7..5 are dropped
	function automatic logic [`CLP_ENTRY_W-1:0] clp_merge(input logic [`CLP_ENTRY_W-1:0] e,
		input logic odd, input logic [7:0] b);
		logic [`CLP_ENTRY_W-1:0] r;
		r = e;
		if (odd)
		begin
			r[`CLP_FLD_C_LSB +: 4] = b[3:0];
			r[`CLP_FLD_MARK]       = b[`CLP_ODD_MARK];
		end
		else
		begin
			r[`CLP_FLD_A_LSB +: 4] = b[3:0];
			r[`CLP_FLD_B_LSB +: 4] = b[7:4];
		end
		return r;
	endfunction

	// Decode helpers, all from the second synchroniser stage onward
	logic [`CLP_SY_W-1:0] cur;
	logic [`CLP_SY_W-1:0] prv;
	logic                 nonmux;
	logic                 live_sel;
	logic                 astb_fall;
	logic                 dstb_fall;
	logic                 dstb_rise;
	logic                 rw_rise;
	logic                 dot_rise;
	logic [7:0]           ad;
	logic                 sel_now;
	logic                 rd_active;
	logic                 wr_evt;
	logic                 rd_done;
	logic                 ptr_load;
	logic                 ptr_step;
	logic                 force_low;

	// Next-state logic
	always_comb
	begin
		n = q;

		// Every pin passes two flops; edges are taken between stages two and three
		n.sy1 = {link.bus, link.pixel_index, link.mode_sel, link.blanking, link.dot_clock,
			link.chip_select_hi, link.chip_select_n, link.rw_sel, link.data_strobe,
			link.addr_latch_strobe};
		n.sy2 = q.sy1;
		n.sy3 = q.sy2;
		cur   = q.sy2;
		prv   = q.sy3;

		nonmux   = cur[`CLP_SY_MODE];
		live_sel = !cur[`CLP_SY_CSN] && cur[`CLP_SY_CSH];
		ad       = cur[`CLP_SY_AD +: 8];
		astb_fall = prv[`CLP_SY_ASTB] && !cur[`CLP_SY_ASTB];
		dstb_fall = prv[`CLP_SY_DSTB] && !cur[`CLP_SY_DSTB];
		dstb_rise = !prv[`CLP_SY_DSTB] && cur[`CLP_SY_DSTB];
		rw_rise   = !prv[`CLP_SY_RW] && cur[`CLP_SY_RW];
		dot_rise  = !prv[`CLP_SY_DOT] && cur[`CLP_SY_DOT];

		// Multiplexed address phase: latch address, strobe style and selection
		if (!nonmux && astb_fall)
		begin
			n.ptr       = ad[`CLP_PTR_W-1:0];
			n.ale_style = cur[`CLP_SY_DSTB];
			n.cs_lat    = live_sel;
		end

		// Selection seen by the output forcing and the bus buffers
		if (nonmux)
		begin
			sel_now   = live_sel;
			rd_active = live_sel && cur[`CLP_SY_DSTB] && cur[`CLP_SY_RW] && !cur[`CLP_SY_ASTB];
			ptr_load  = live_sel && dstb_fall && cur[`CLP_SY_ASTB] && !cur[`CLP_SY_RW];
			ptr_step  = live_sel && dstb_fall && !cur[`CLP_SY_ASTB];
			wr_evt    = ptr_step && !cur[`CLP_SY_RW];
			rd_done   = 1'b0;
		end
		else if (q.ale_style)
		begin
			// Latch-enable style: read and write strobes are both active low
			sel_now   = q.cs_lat && (!cur[`CLP_SY_DSTB] || !cur[`CLP_SY_RW]);
			rd_active = q.cs_lat && !cur[`CLP_SY_DSTB];
			wr_evt    = q.cs_lat && rw_rise;
			rd_done   = q.cs_lat && dstb_rise;
			ptr_load  = 1'b0;
			ptr_step  = 1'b0;
		end
		else
		begin
			// Enable-clock style: data phase while the strobe is high
			sel_now   = q.cs_lat && cur[`CLP_SY_DSTB];
			rd_active = q.cs_lat && cur[`CLP_SY_DSTB] && cur[`CLP_SY_RW];
			wr_evt    = q.cs_lat && dstb_fall && !cur[`CLP_SY_RW];
			rd_done   = q.cs_lat && dstb_fall && cur[`CLP_SY_RW];
			ptr_load  = 1'b0;
			ptr_step  = 1'b0;
		end

		// Processor write into the addressed byte
		if (wr_evt)
		begin
			n.pal[q.ptr[`CLP_PTR_W-1:1]] = clp_merge(q.pal[q.ptr[`CLP_PTR_W-1:1]], q.ptr[0], ad);
		end

		// Latched selection covers one cycle; kept stale it would drive the bus when the style changes
		if (wr_evt || rd_done)
		begin
			n.cs_lat = 1'b0;
		end

		// Write-only pointer load, then auto-increment after each window access
		if (ptr_load)
		begin
			n.ptr = ad[`CLP_PTR_W-1:0];
		end
		else if (ptr_step)
		begin
			n.ptr = q.ptr + `CLP_PTR_W'(1);
		end

		// Any finished processor access ends the post-reset hold
		if (wr_evt || rd_done || ptr_load || ptr_step)
		begin
			n.hold = 1'b0;
		end

		// Read data and buffer enable are registered so the bus never sees a glitch
		n.dout = clp_byte(q.pal[q.ptr[`CLP_PTR_W-1:1]], q.ptr[0]);
		n.doe  = rd_active;

		// Pixel pipeline: new index in, previously indexed entry to the stage
		if (dot_rise)
		begin
			n.idx       = cur[`CLP_SY_PIX +: 4];
			n.blank_lat   = cur[`CLP_SY_BLANK];
			n.stage       = q.pal[q.idx];
			n.stage_blank = q.blank_lat;
		end

		// Outputs forced low by blanking, selection or the reset hold
		force_low = q.stage_blank || sel_now || q.hold;
		n.col     = force_low ? 12'h000 : q.stage[11:0];
		n.mark    = force_low ? 1'b0 : q.stage[`CLP_FLD_MARK];
	end

	// State register; the hold flag starts set so the screen stays black
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			q      <= '0;
			q.ptr  <= `CLP_PTR_RST;
			q.hold <= 1'b1;
		end
		else
		begin
			q <= n;
		end
	end

	// Outputs straight from flops
	assign colour_out_first  = q.col[`CLP_FLD_A_LSB +: 4];
	assign colour_out_second = q.col[`CLP_FLD_B_LSB +: 4];
	assign colour_out_third  = q.col[`CLP_FLD_C_LSB +: 4];
	assign overlay_flag      = q.mark;
	assign link.dev_bus_out  = q.dout;
	assign link.dev_bus_oe   = q.doe;

endmodule

//--- rtl/clp_palette_host.sv
`timescale 1ns/100ps
module clp_palette_host
	import clp_pkg::*;
#(
	parameter int unsigned DOT_HALF = `CLP_DOT_HALF // Dot clock half period, cycles
)
(
	input  wire logic        sys_clk, // System clock
	input  wire logic        rst,     // Asynchronous reset, active high
	clp_link_if.host         link,    // Pins toward the palette
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready, no wait states
	output logic             pslverr  // APB error on unmapped address
);

	// Phase length rounded up to whole cycles
	localparam int unsigned PH_CYC = (`CLP_STROBE_NS * `CLP_SYS_MHZ + 999) / 1000;
	localparam logic [7:0]  PH_LD  = 8'(PH_CYC - 1);
	localparam logic [7:0]  DOT_LD = 8'(DOT_HALF - 1);

	clp_host_state_t q;
	clp_host_state_t n;
	logic            acc;
	logic            mapped;
	logic            ale_style;

	// APB decode and read mux
	always_comb
	begin
		acc     = psel && penable;
		pready  = acc;
		mapped  = (paddr == `CLP_REG_CTRL) || (paddr == `CLP_REG_CMD) ||
			(paddr == `CLP_REG_STATUS) || (paddr == `CLP_REG_VIDEO);
		pslverr = acc && !mapped;
		prdata  = 32'h00000000;
		unique case (paddr)
			`CLP_REG_CTRL:   prdata[2:0] = q.ctrl;
			`CLP_REG_STATUS:
			begin
				prdata[`CLP_STAT_BUSY]          = (q.st != CLP_IDLE);
				prdata[`CLP_STAT_RDATA_LSB +: 8] = q.rdata;
			end
			`CLP_REG_VIDEO:
			begin
				prdata[`CLP_VID_PIX_LSB +: 4] = q.pix;
				prdata[`CLP_VID_BLANK]        = q.blank;
			end
			default:         prdata = 32'h00000000;
		endcase
	end

	// Next-state logic
	always_comb
	begin
		n     = q;
		ale_style = q.ctrl[`CLP_CTRL_ALE];

		// Register writes; a command while busy is dropped
		if (acc && pwrite && paddr == `CLP_REG_CTRL)
		begin
			n.ctrl = pwdata[2:0];
		end
		if (acc && pwrite && paddr == `CLP_REG_VIDEO)
		begin
			n.pix   = pwdata[`CLP_VID_PIX_LSB +: 4];
			n.blank = pwdata[`CLP_VID_BLANK];
		end

		// Phase sequencer
		unique case (q.st)
			CLP_IDLE:
			begin
				if (acc && pwrite && paddr == `CLP_REG_CMD)
				begin
					n.cdata = pwdata[`CLP_CMD_DATA_LSB +: 8];
					n.caddr = pwdata[`CLP_CMD_ADDR_LSB +: `CLP_PTR_W];
					n.cread = pwdata[`CLP_CMD_READ] && !pwdata[`CLP_CMD_PTR];
					n.cptr  = pwdata[`CLP_CMD_PTR];
					n.st    = CLP_ADDR;
					n.cnt   = PH_LD;
				end
			end
			CLP_ADDR:
			begin
				if (q.cnt == 8'h00)
				begin
					n.st  = q.ctrl[`CLP_CTRL_NONMUX] ? CLP_DATA : CLP_LATCH;
					n.cnt = PH_LD;
				end
				else
				begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			CLP_LATCH:
			begin
				if (q.cnt == 8'h00)
				begin
					n.st  = CLP_DATA;
					n.cnt = PH_LD;
				end
				else
				begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			CLP_DATA:
			begin
				if (q.cnt == 8'h00)
				begin
					n.rdata = q.cread ? link.bus : q.rdata;
					n.st    = CLP_RECOVER;
					n.cnt   = PH_LD;
				end
				else
				begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			CLP_RECOVER:
			begin
				if (q.cnt == 8'h00)
				begin
					n.st = CLP_IDLE;
				end
				else
				begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			default:
			begin
				n.st = CLP_IDLE;
			end
		endcase

		// Pin levels follow the next phase; idle strobes rest inactive
		n.astb = 1'b0;
		n.dstb = ale_style;
		n.rw   = 1'b1;
		n.csn  = (n.st == CLP_IDLE);
		n.csh  = (n.st != CLP_IDLE);
		n.bout = q.cdata;
		n.boe  = 1'b0;
		if (q.ctrl[`CLP_CTRL_NONMUX])
		begin
			// Indirect: strobe picks pointer or window; pointer reload is software's choice
			n.astb = q.cptr && (n.st != CLP_IDLE);
			n.rw   = q.cread || (n.st == CLP_IDLE);
			n.bout = q.cptr ? {3'b000, q.caddr} : q.cdata;
			n.boe  = !q.cread && (n.st != CLP_IDLE);
			n.dstb = (n.st == CLP_DATA);
		end
		else
		begin
			n.astb = (n.st == CLP_ADDR);
			n.bout = (n.st == CLP_ADDR || n.st == CLP_LATCH) ? {3'b000, q.caddr} : q.cdata;
			n.boe  = (n.st == CLP_ADDR || n.st == CLP_LATCH) ||
				(!q.cread && (n.st == CLP_DATA || n.st == CLP_RECOVER));
			if (ale_style)
			begin
				n.dstb = !(n.st == CLP_DATA && q.cread);
				n.rw = !(n.st == CLP_DATA && !q.cread);
			end
			else
			begin
				n.dstb = (n.st == CLP_DATA);
				n.rw = q.cread || (n.st != CLP_DATA && n.st != CLP_RECOVER);
			end
		end

		// Dot clock divider, stopped low when not running
		if (!q.ctrl[`CLP_CTRL_DOTRUN])
		begin
			n.dot     = 1'b0;
			n.dot_cnt = DOT_LD;
		end
		else if (q.dot_cnt == 8'h00)
		begin
			n.dot     = !q.dot;
			n.dot_cnt = DOT_LD;
		end
		else
		begin
			n.dot_cnt = q.dot_cnt - 8'h01;
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			q      <= '0;
			q.ctrl <= `CLP_CTRL_RST;
			q.st   <= CLP_IDLE;
			q.rw   <= 1'b1;
			q.csn  <= 1'b1;
		end
		else
		begin
			q <= n;
		end
	end

	// Pins straight from flops
	assign link.mode_sel          = q.ctrl[`CLP_CTRL_NONMUX];
	assign link.addr_latch_strobe = q.astb;
	assign link.data_strobe       = q.dstb;
	assign link.rw_sel            = q.rw;
	assign link.chip_select_n     = q.csn;
	assign link.chip_select_hi    = q.csh;
	assign link.host_bus_out      = q.bout;
	assign link.host_bus_oe       = q.boe;
	assign link.dot_clock         = q.dot;
	assign link.pixel_index       = q.pix;
	assign link.blanking          = q.blank;

endmodule

//--- tb/clp_props.sv
`timescale 1ns/100ps
module clp_props
(
	input wire logic sys_clk,           // System clock
	input wire logic rst,               // Asynchronous reset, active high
	input wire logic mode_sel,          // Bus mode pin
	input wire logic addr_latch_strobe, // Address latch strobe
	input wire logic data_strobe,       // Data strobe
	input wire logic rw_sel,            // Read/write select
	input wire logic chip_select_n,     // Active-low select
	input wire logic chip_select_hi,    // Active-high select
	input wire logic host_bus_oe,       // Controller drives bus
	input wire logic dev_bus_oe         // Palette drives bus
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Both selects always move as one pair
	a_select_pair: assert property (chip_select_n != chip_select_hi)
		else $error("chip selects not paired");
	// Palette drives only while fully selected
	a_drive_selected: assert property (dev_bus_oe |-> !chip_select_n && chip_select_hi)
		else $error("palette drives bus while not selected");
	// Palette drives only for reads
	a_read_drive: assert property (dev_bus_oe |-> rw_sel)
		else $error("palette drives bus during a write");
	// Two drivers on the bus would corrupt data
	a_no_contention: assert property (!(dev_bus_oe && host_bus_oe))
		else $error("bus driven by both ends");
	// Reads come from the data location, never the pointer
	a_drive_window: assert property ($rose(dev_bus_oe) |-> !addr_latch_strobe)
		else $error("palette drives bus with address strobe high");
	// Indirect mode: buffers follow the data strobe closely
	a_oe_release: assert property (mode_sel && $fell(data_strobe) |-> ##[1:6] !dev_bus_oe)
		else $error("palette bus drive outlives data strobe");
	// Mode pin only moves while the palette is idle
	a_mode_change: assert property ($changed(mode_sel) |-> chip_select_n)
		else $error("mode changed during a selected cycle");
	// Indirect mode: direction must not move inside a data strobe
	a_rw_hold: assert property (mode_sel && !chip_select_n && data_strobe && $past(data_strobe)
		|-> $stable(rw_sel))
		else $error("direction changed inside data strobe");
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
`include "clp_regs.svh"
module tb;
	import clp_pkg::*;

	logic        sys_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  c1;
	logic [3:0]  c2;
	logic [3:0]  c3;
	logic        ovl;
	logic [31:0] q;
	logic        e;
	int          fail_count;
	int          num_checks;
	int          cyc;

	clp_link_if i_clp_link_if ();

	// Short dot half period keeps video checks brief
	clp_palette_host #(.DOT_HALF(1)) i_clp_palette_host
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.link    (i_clp_link_if),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	clp_palette_dev i_clp_palette_dev
	(
		.sys_clk           (sys_clk),
		.rst               (rst),
		.link              (i_clp_link_if),
		.colour_out_first  (c1),
		.colour_out_second (c2),
		.colour_out_third  (c3),
		.overlay_flag      (ovl)
	);

	clp_props i_clp_props
	(
		.sys_clk           (sys_clk),
		.rst               (rst),
		.mode_sel          (i_clp_link_if.mode_sel),
		.addr_latch_strobe (i_clp_link_if.addr_latch_strobe),
		.data_strobe       (i_clp_link_if.data_strobe),
		.rw_sel            (i_clp_link_if.rw_sel),
		.chip_select_n     (i_clp_link_if.chip_select_n),
		.chip_select_hi    (i_clp_link_if.chip_select_hi),
		.host_bus_oe       (i_clp_link_if.host_bus_oe),
		.dev_bus_oe        (i_clp_link_if.dev_bus_oe)
	);

	// 100 ns system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, tests need well under two thousand cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fail_count++;
			$display("wrong value at %0t: run timed out", $time);
			conclude();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pix(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: video %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; entered just after a rising edge, returns one idle edge later
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this time step
		@(posedge sys_clk);
	endtask

	function automatic logic [31:0] cw(input logic rd, input logic ptr, input logic [4:0] a, input logic [7:0] d);
		return {14'h0000, ptr, rd, 3'h0, a, d};
	endfunction

	// Issue a link command and poll until the controller is idle again
	task automatic cmd(input logic [31:0] w, output logic [31:0] st);
		logic er;
		apb(1'b1, `CLP_REG_CMD, w, st, er);
		do
			apb(1'b0, `CLP_REG_STATUS, 32'h0, st, er);
		while (st[`CLP_STAT_BUSY] !== 1'b0);
	endtask

	task automatic rd_byte(input logic [4:0] a, input logic [7:0] exp);
		logic [31:0] st;
		cmd(cw(1'b1, 1'b0, a, 8'h00), st);
		chk_word({24'h000000, st[15:8]}, {24'h000000, exp});
	endtask

	// Select a pixel, let the dot pipeline settle, compare outputs
	task automatic vid(input logic [3:0] pix, input logic blank, input logic [12:0] exp);
		apb(1'b1, `CLP_REG_VIDEO, {27'h0000000, blank, pix}, q, e);
		repeat (30) @(posedge sys_clk);
		chk_pix({ovl, c3, c2, c1}, exp);
	endtask

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Reset state and an unmapped access
		chk_pix({ovl, c3, c2, c1}, 13'h0000);
		apb(1'b0, `CLP_REG_CTRL, 32'h0, q, e);
		chk_word(q, 32'h00000000);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk_word({q[30:0], e}, 32'h00000001);
		$display("test reset done");
		// Multiplexed, enable-clock host: even and odd bytes of entry 3
		cmd(cw(1'b0, 1'b0, 5'h06, 8'hA5), q);
		cmd(cw(1'b0, 1'b0, 5'h07, 8'hFC), q);
		rd_byte(5'h06, 8'hA5);
		rd_byte(5'h07, 8'h1C);
		$display("test multiplexed done");
		// Latch-enable host style
		apb(1'b1, `CLP_REG_CTRL, 32'h00000002, q, e);
		cmd(cw(1'b0, 1'b0, 5'h08, 8'h5A), q);
		rd_byte(5'h08, 8'h5A);
		$display("test latch style done");
		// Indirect mode: pointer wraps from 31 to 0
		apb(1'b1, `CLP_REG_CTRL, 32'h00000001, q, e);
		cmd(cw(1'b0, 1'b1, 5'h1F, 8'h1F), q);
		cmd(cw(1'b0, 1'b0, 5'h00, 8'h13), q);
		cmd(cw(1'b0, 1'b0, 5'h00, 8'h21), q);
		cmd(cw(1'b0, 1'b1, 5'h1F, 8'h1F), q);
		rd_byte(5'h00, 8'h13);
		rd_byte(5'h00, 8'h21);
		$display("test indirect done");
		// Video path with the dot clock running
		apb(1'b1, `CLP_REG_CTRL, 32'h00000005, q, e);
		vid(4'h3, 1'b0, 13'h1CA5);
		vid(4'hF, 1'b0, 13'h1300);
		// Outputs go dark while the palette is selected by a pointer load
		apb(1'b1, `CLP_REG_CMD, cw(1'b0, 1'b1, 5'h00, 8'h00), q, e);
		repeat (8) @(posedge sys_clk);
		chk_pix({ovl, c3, c2, c1}, 13'h0000);
		repeat (20) @(posedge sys_clk);
		vid(4'h3, 1'b1, 13'h0000);
		vid(4'h0, 1'b0, 13'h0021);
		$display("test video done");
		conclude();
	end
endmodule
